// ==== src/scd_decoder.sv ====
// command and clock-enable decoder of a ddr3-class sdram
`timescale 1ns/1ps
// Operation
// - sample strobes and cke every rising edge
// - termination input ignored by decoding
// - bank address picks bank or mode register
// - self refresh exit recognised asynchronously
// - started bursts always run to completion
// - mode register 0 picks fixed or otf
// - no-operation registers nothing, keeps operations
// - deselect behaves exactly like no-operation
// - no internal refresh during power-down
// - first long zq is initial calibration
// - transition uses prior state and both cke
// - idle needs banks closed, no burst, settled
// - action follows the registered legal command
// - otf chop four when a12 low
module scd_decoder #(
  parameter int BURST8 = scd_pkg::BURST_CYC8,
  parameter int BURST4 = scd_pkg::BURST_CYC4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire scd_pkg::scd_bus_t cmd_bus,
  input wire logic cke,
  input wire logic odt,
  output scd_pkg::scd_dec_t dec,
  output logic dec_valid,
  output scd_pkg::scd_state_t state,
  output logic [scd_pkg::NUM_BANKS-1:0] bank_open,
  output logic burst_busy,
  output logic refresh_allowed,
  output logic is_idle,
  output logic sref_exit
);
  import scd_pkg::*;

  // odt deliberately has no path into decoding or cke state
  logic odt_unused;
  assign odt_unused = odt;

  // decode the strobe pattern into a command kind
  function automatic scd_cmd_t enc_cmd(input logic [2:0] enc, input logic a10);
    unique case (enc)
      ENC_MRS: enc_cmd = CMD_MRS;
      ENC_REF: enc_cmd = CMD_REF;
      ENC_PRE: enc_cmd = CMD_PRE;
      ENC_ACT: enc_cmd = CMD_ACT;
      ENC_WR: enc_cmd = CMD_WR;
      ENC_RD: enc_cmd = CMD_RD;
      ENC_ZQ: enc_cmd = a10 ? CMD_ZQCL : CMD_ZQCS;
      ENC_NOP: enc_cmd = CMD_NONE;
    endcase
  endfunction : enc_cmd

  // banks still open after an exit or command decide active or idle
  function automatic scd_state_t run_state(input logic [NUM_BANKS-1:0] open);
    run_state = (open != '0) ? ST_ACTIVE : ST_IDLE;
  endfunction : run_state

  // registered state
  logic cke_prev;                            // cke at edge n-1
  logic [ADDR_W-1:0] mr [NUM_MR];            // four mode registers
  logic [3:0] burst_cnt;                     // remaining burst cycles
  logic [3:0] settle_cnt;                    // cycles since cke came high
  logic zq_done;                             // initial calibration seen
  // next values, one per registered piece
  logic next_cke_prev;
  logic [ADDR_W-1:0] next_mr [NUM_MR];
  logic [3:0] next_burst_cnt;
  logic [3:0] next_settle_cnt;
  logic next_zq_done;
  scd_state_t next_state;
  logic [NUM_BANKS-1:0] next_bank_open;
  scd_dec_t next_dec;
  logic next_dec_valid;

  // combinational decode of the sampled pins
  logic [2:0] enc;
  scd_cmd_t raw;
  logic [1:0] bl_mode;
  assign enc = {cmd_bus.ras_n, cmd_bus.cas_n, cmd_bus.we_n};
  // deselect and no-operation both fold to none
  assign raw = cmd_bus.cs_n ? CMD_NONE : enc_cmd(enc, cmd_bus.addr[AP_BIT]);
  assign bl_mode = mr[0][MR0_BL_LSB +: 2];

  // self refresh exit seen as soon as cke rises, not on an edge
  assign sref_exit = (state == ST_SREF) && cke;
  assign burst_busy = (burst_cnt != 4'h0);
  // idle: banks closed, no burst, cke high and exit timing met
  // the settle count stands in for exit timing that the pins cannot show
  assign is_idle = (state == ST_IDLE) && (bank_open == '0) && !burst_busy && cke
                   && (settle_cnt >= CKE_MIN_CYC);
  // internal refresh only in self refresh, never in power-down
  assign refresh_allowed = (state == ST_SREF);

  // all banks idle and no burst at the entering edge
  function automatic logic is_idle_pre();
    is_idle_pre = (bank_open == '0) && !burst_busy;
  endfunction : is_idle_pre

  // next-state logic for every tracked piece
  always_comb begin
    next_cke_prev = cke;
    next_mr = mr;
    next_burst_cnt = burst_busy ? burst_cnt - 4'h1 : 4'h0;  // burst cannot be cut
    // settle count saturates so a long high level never wraps
    next_settle_cnt = (!cke) ? 4'h0 : ((settle_cnt == 4'hf) ? settle_cnt : settle_cnt + 4'h1);
    next_zq_done = zq_done;
    next_state = state;
    next_bank_open = bank_open;
    next_dec = dec;
    next_dec_valid = 1'b0;
    // transition from prior state with cke at n-1 and n
    unique case (state)
      ST_APD, ST_PPD, ST_SREF: begin
        // cke low-low maintains; a rise with nop or deselect exits
        // commands seen here are dropped, the controller owns their timing
        if (!cke_prev && cke && raw == CMD_NONE) begin
          next_state = run_state(bank_open);  // back to active or idle
        end
      end
      ST_IDLE, ST_ACTIVE: begin
        // cke falling: only nop, deselect or refresh are legal here
        if (cke_prev && !cke) begin
          if (raw == CMD_REF && is_idle_pre()) begin
            // refresh with nothing open or running: self refresh
            next_state = ST_SREF;
            next_dec.cmd = CMD_SRE;
            next_dec_valid = 1'b1;
          end else if (raw == CMD_NONE) begin
            // nop or deselect: power-down kind follows the open banks
            next_state = (bank_open != '0) ? ST_APD : ST_PPD;
            next_dec.cmd = CMD_PDE;
            next_dec_valid = 1'b1;
          end
        end else if (cke_prev && cke && raw != CMD_NONE) begin
          // a registered legal command drives the action
          next_dec.cmd = raw;
          next_dec.bank = cmd_bus.ba;
          next_dec.addr = cmd_bus.addr;
          next_dec.all_banks = cmd_bus.addr[AP_BIT];
          next_dec.chop4 = 1'b0;
          next_dec.zq_init = 1'b0;
          next_dec_valid = 1'b1;
          // mode register writes and bank flags land at this edge
          unique case (raw)
            CMD_MRS: next_mr[cmd_bus.ba[MR_W-1:0]] = cmd_bus.addr;
            // activate keeps the row open until a precharge
            CMD_ACT: next_bank_open[cmd_bus.ba] = 1'b1;
            CMD_PRE: begin
              if (cmd_bus.addr[AP_BIT]) begin
                next_bank_open = '0;
              end else begin
                next_bank_open[cmd_bus.ba] = 1'b0;
              end
            end
            CMD_RD, CMD_WR: begin
              // fixed from mode register, else a12 per command
              next_dec.chop4 = (bl_mode == MR0_BL_OTF) ? !cmd_bus.addr[OTF_BIT]
                               : (bl_mode == MR0_BL_FIXED4);
              // a new burst waits behind, never truncates the old one
              // limitation: the waiting burst is not counted on its own
              if (!burst_busy) begin
                next_burst_cnt = next_dec.chop4 ? 4'(BURST4) : 4'(BURST8);
              end
              // auto precharge closes the addressed bank
              if (cmd_bus.addr[AP_BIT]) begin
                next_bank_open[cmd_bus.ba] = 1'b0;
              end
            end
            CMD_ZQCL: begin
              // only the first long calibration after reset is initial
              next_dec.zq_init = !zq_done;
              next_zq_done = 1'b1;
            end
            default: begin
            end
          endcase
          // state follows the banks left open by this command
          next_state = run_state(next_bank_open);
        end
      end
      default: begin
        // an illegal one-hot code recovers to idle
        next_state = ST_IDLE;
      end
    endcase
  end

  // register stage; reset pin is the only reset path
  // synchronous reset keeps every flop on one clean path
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cke_prev <= 1'b0;
      for (int i = 0; i < NUM_MR; i++) begin
        mr[i] <= MR_RESET;
      end
      burst_cnt <= 4'h0;
      settle_cnt <= 4'h0;
      zq_done <= 1'b0;
      state <= ST_IDLE;
      bank_open <= '0;
      dec <= '{cmd: CMD_NONE, bank: '0, all_banks: 1'b0, chop4: 1'b0, zq_init: 1'b0, addr: '0};
      dec_valid <= 1'b0;
    end else begin
      // every piece takes its next value on every edge
      cke_prev <= next_cke_prev;
      mr <= next_mr;
      burst_cnt <= next_burst_cnt;
      settle_cnt <= next_settle_cnt;
      zq_done <= next_zq_done;
      state <= next_state;
      bank_open <= next_bank_open;
      dec <= next_dec;
      dec_valid <= next_dec_valid;
    end
  end
endmodule : scd_decoder

// ==== src/scd_pkg.sv ====
// package for the sdram command and clock-enable decoder
package scd_pkg;
  localparam int BANK_W = 3;
  localparam int NUM_BANKS = 8;
  localparam int ADDR_W = 16;
  localparam int AP_BIT = 10;          // all-bank / long-zq select
  localparam int OTF_BIT = 12;         // chop select on the fly
  localparam int NUM_MR = 4;
  localparam int MR_W = 2;
  localparam int MR0_BL_LSB = 0;       // burst length field in mode register 0
  localparam logic [1:0] MR0_BL_FIXED8 = 2'h0;
  localparam logic [1:0] MR0_BL_OTF = 2'h1;
  localparam logic [1:0] MR0_BL_FIXED4 = 2'h2;
  localparam logic [ADDR_W-1:0] MR_RESET = 16'h0000;
  localparam int BURST_CYC8 = 4;       // clock cycles of an eight-beat burst
  localparam int BURST_CYC4 = 2;       // clock cycles of a chopped burst
  localparam logic [3:0] CKE_MIN_CYC = 4'h3;  // idle only after exit settle

  // row, column, write strobe encodings (active low levels)
  localparam logic [2:0] ENC_MRS = 3'h0;
  localparam logic [2:0] ENC_REF = 3'h1;
  localparam logic [2:0] ENC_PRE = 3'h2;
  localparam logic [2:0] ENC_ACT = 3'h3;
  localparam logic [2:0] ENC_WR = 3'h4;
  localparam logic [2:0] ENC_RD = 3'h5;
  localparam logic [2:0] ENC_ZQ = 3'h6;
  localparam logic [2:0] ENC_NOP = 3'h7;

  typedef enum logic [10:0] {
    CMD_NONE = 11'h001, CMD_MRS = 11'h002, CMD_REF = 11'h004, CMD_PRE = 11'h008,
    CMD_ACT = 11'h010, CMD_WR = 11'h020, CMD_RD = 11'h040, CMD_ZQCL = 11'h080,
    CMD_ZQCS = 11'h100, CMD_SRE = 11'h200, CMD_PDE = 11'h400
  } scd_cmd_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_ACTIVE = 5'h02, ST_APD = 5'h04, ST_PPD = 5'h08, ST_SREF = 5'h10
  } scd_state_t;

  // command pins as sampled at one edge
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } scd_bus_t;

  // decoded command handed to the core
  typedef struct packed {
    scd_cmd_t cmd;
    logic [BANK_W-1:0] bank;
    logic all_banks;
    logic chop4;
    logic zq_init;
    logic [ADDR_W-1:0] addr;
  } scd_dec_t;
endpackage : scd_pkg

// ==== verification/scd_chk.sv ====
// port assertions for the command decoder
`timescale 1ns/1ps
module scd_chk #(
  parameter int BURST8 = scd_pkg::BURST_CYC8,
  parameter int BURST4 = scd_pkg::BURST_CYC4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire scd_pkg::scd_bus_t cmd_bus,
  input wire logic cke,
  input wire logic odt,
  input wire scd_pkg::scd_dec_t dec,
  input wire logic dec_valid,
  input wire scd_pkg::scd_state_t state,
  input wire logic [scd_pkg::NUM_BANKS-1:0] bank_open,
  input wire logic burst_busy,
  input wire logic refresh_allowed,
  input wire logic is_idle,
  input wire logic sref_exit
);
  import scd_pkg::*;
  localparam int B8 = BURST8 - 1;
  localparam int B4 = BURST4 - 1;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire nopdes = cmd_bus.cs_n | (&{cmd_bus.ras_n, cmd_bus.cas_n, cmd_bus.we_n});
  wire run = state inside {ST_IDLE, ST_ACTIVE};
  // strobe pattern to expected command
  function automatic scd_cmd_t xcmd(input scd_bus_t b);
    case ({b.ras_n, b.cas_n, b.we_n})
      ENC_MRS: return CMD_MRS;
      ENC_REF: return CMD_REF;
      ENC_PRE: return CMD_PRE;
      ENC_ACT: return CMD_ACT;
      ENC_WR: return CMD_WR;
      ENC_RD: return CMD_RD;
      ENC_ZQ: return b.addr[AP_BIT] ? CMD_ZQCL : CMD_ZQCS;
      default: return CMD_NONE;
    endcase
  endfunction : xcmd
  sequence s_hi;
    cke && $past(cke);
  endsequence
  sequence s_fall;
    $past(cke) && !cke && run && !burst_busy;
  endsequence
  sequence s_end4;
    ##B4 burst_busy ##1 !burst_busy;
  endsequence
  sequence s_end8;
    ##B8 burst_busy ##1 !burst_busy;
  endsequence
  a_nop_quiet: assert property (s_hi ##0 nopdes |=> !dec_valid)
    else $error("nop or deselect produced a command");
  a_cmd_taken: assert property (s_hi ##0 (!nopdes && run) |=> dec_valid && dec.cmd == xcmd($past(cmd_bus)))
    else $error("command not decoded");
  a_bank_sel: assert property (dec_valid && !(dec.cmd inside {CMD_PDE, CMD_SRE}) |->
    dec.bank == $past(cmd_bus.ba) && dec.all_banks == $past(cmd_bus.addr[AP_BIT]))
    else $error("bank or all-bank field wrong");
  a_sref_exit: assert property (sref_exit == (state == ST_SREF && cke))
    else $error("self refresh exit not immediate");
  a_pd_no_ref: assert property (state inside {ST_APD, ST_PPD} |-> !refresh_allowed)
    else $error("refresh in power-down");
  a_pd_entry: assert property (s_fall ##0 nopdes |=> state == (bank_open == 0 ? ST_PPD : ST_APD))
    else $error("power-down entry wrong");
  a_sr_entry: assert property (s_fall ##0 (!nopdes && !bank_open && cmd_bus[21:19] == ENC_REF) |=> state == ST_SREF)
    else $error("self refresh entry missed");
  a_pd_exit: assert property (!run && !$past(cke) && cke && nopdes |=> run)
    else $error("power state exit missed");
  a_burst_end: assert property (dec_valid && dec.cmd inside {CMD_RD, CMD_WR} && !$past(burst_busy) |->
    if (dec.chop4) s_end4 else s_end8)
    else $error("burst length wrong");
  a_idle_cond: assert property (is_idle |-> state == ST_IDLE && !bank_open && !burst_busy && cke)
    else $error("idle flagged too early");
endmodule : scd_chk
bind scd_decoder scd_chk #(.BURST8(BURST8), .BURST4(BURST4)) u_chk (.ref_clk(ref_clk), .nrst(nrst),
  .cmd_bus(cmd_bus), .cke(cke), .odt(odt), .dec(dec), .dec_valid(dec_valid), .state(state), .bank_open(bank_open),
  .burst_busy(burst_busy), .refresh_allowed(refresh_allowed), .is_idle(is_idle), .sref_exit(sref_exit));

// ==== verification/scd_ctl_model.sv ====
// controller model driving the command pins
`timescale 1ns/1ps
module scd_ctl_model (
  input wire logic ref_clk,
  output scd_pkg::scd_bus_t cmd_bus,
  output logic cke,
  output logic odt
);
  import scd_pkg::*;
  initial begin
    cmd_bus = '1;
    cke = 1'b1;
    odt = 1'b0;
  end
  // termination flips every cycle so decoding must ignore it
  always @(posedge ref_clk) odt <= ~odt;
  // one command then nop; deselect scrambles strobes, address moves off
  task automatic send(input logic cs, input logic [2:0] enc, input logic k, input logic [2:0] b,
    input logic [15:0] a);
    @(posedge ref_clk);
    cke <= k;
    cmd_bus <= {cs, cs ? ~enc : enc, b, a};
    @(posedge ref_clk);
    cmd_bus <= {1'b0, ENC_NOP, ~b, ~a};
  endtask : send
endmodule : scd_ctl_model

// ==== verification/tb.sv ====
// self-checking bench for the command decoder
`timescale 1ns/1ps
module tb;
  import scd_pkg::*;
  `define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  int error_cnt = 0;
  int n_checks = 0;
  scd_bus_t cmd_bus;
  scd_dec_t dec;
  scd_state_t state;
  logic [NUM_BANKS-1:0] bank_open;
  logic cke, odt, dec_valid, burst_busy, refresh_allowed, is_idle, sref_exit;
  always #5 ref_clk = ~ref_clk;
  scd_ctl_model ctl (.ref_clk(ref_clk), .cmd_bus(cmd_bus), .cke(cke), .odt(odt));
  scd_decoder dut (.ref_clk(ref_clk), .nrst(nrst), .cmd_bus(cmd_bus), .cke(cke), .odt(odt), .dec(dec),
    .dec_valid(dec_valid), .state(state), .bank_open(bank_open), .burst_busy(burst_busy),
    .refresh_allowed(refresh_allowed), .is_idle(is_idle), .sref_exit(sref_exit));
  // issue with cke held high, then judge the one-cycle answer
  task automatic step(input logic cs, input logic [2:0] enc, input logic [2:0] b, input logic [15:0] a,
    input logic v, input scd_cmd_t c);
    ctl.send(cs, enc, 1'b1, b, a);
    #1;
    `CHK("dec_valid", v, dec_valid)
    if (v) `CHK("dec.cmd", c, dec.cmd)
  endtask : step
  // cke change with a given pattern, then state check
  task automatic ck(input logic [2:0] enc, input logic k, input scd_state_t s);
    ctl.send(1'b0, enc, k, 3'h0, 16'h0000);
    #1;
    `CHK("state", s, state)
  endtask : ck
  task automatic t_decode();
    step(1'b0, ENC_ZQ, 3'h0, 16'h0400, 1'b1, CMD_ZQCL);
    `CHK("zq_init", 1'b1, dec.zq_init)
    step(1'b0, ENC_ZQ, 3'h0, 16'h0400, 1'b1, CMD_ZQCL);
    `CHK("zq_init", 1'b0, dec.zq_init)
    step(1'b0, ENC_ZQ, 3'h0, 16'h0000, 1'b1, CMD_ZQCS);
    step(1'b0, ENC_REF, 3'h0, 16'h0000, 1'b1, CMD_REF);
    step(1'b1, ENC_NOP, 3'h3, 16'h0001, 1'b0, CMD_NONE);
    step(1'b0, ENC_NOP, 3'h1, 16'h0400, 1'b0, CMD_NONE);
    step(1'b0, ENC_MRS, 3'h4, 16'h0001, 1'b1, CMD_MRS);
    `CHK("dec.addr", 16'h0001, dec.addr)
  endtask : t_decode
  task automatic t_burst();
    step(1'b0, ENC_ACT, 3'h2, 16'h0000, 1'b1, CMD_ACT);
    `CHK("bank_open", 8'h04, bank_open)
    step(1'b0, ENC_RD, 3'h2, 16'h0000, 1'b1, CMD_RD);
    `CHK("chop4", 1'b1, dec.chop4)
    `CHK("burst_busy", 1'b1, burst_busy)
    step(1'b0, ENC_NOP, 3'h2, 16'h0000, 1'b0, CMD_NONE);
    step(1'b0, ENC_WR, 3'h2, 16'h1000, 1'b1, CMD_WR);
    `CHK("chop4", 1'b0, dec.chop4)
    step(1'b0, ENC_RD, 3'h2, 16'h1000, 1'b1, CMD_RD);
    step(1'b0, ENC_PRE, 3'h0, 16'h0400, 1'b1, CMD_PRE);
    `CHK("bank_open", 8'h00, bank_open)
    `CHK("all_banks", 1'b1, dec.all_banks)
    step(1'b0, ENC_MRS, 3'h0, 16'h0002, 1'b1, CMD_MRS);
    step(1'b0, ENC_MRS, 3'h1, 16'h0001, 1'b1, CMD_MRS);
    step(1'b0, ENC_ACT, 3'h1, 16'h0000, 1'b1, CMD_ACT);
    `CHK("dec.bank", 3'h1, dec.bank)
    step(1'b0, ENC_RD, 3'h1, 16'h1000, 1'b1, CMD_RD);
    `CHK("chop4", 1'b1, dec.chop4)
    step(1'b0, ENC_MRS, 3'h0, 16'h0000, 1'b1, CMD_MRS);
    step(1'b0, ENC_WR, 3'h1, 16'h0400, 1'b1, CMD_WR);
    `CHK("chop4", 1'b0, dec.chop4)
    `CHK("bank_open", 8'h00, bank_open)
  endtask : t_burst
  task automatic t_power();
    ck(ENC_NOP, 1'b0, ST_PPD);
    `CHK("refresh_allowed", 1'b0, refresh_allowed)
    ck(ENC_NOP, 1'b1, ST_IDLE);
    `CHK("is_idle", 1'b0, is_idle)
    ck(ENC_NOP, 1'b1, ST_IDLE);
    ck(ENC_NOP, 1'b1, ST_IDLE);
    `CHK("is_idle", 1'b1, is_idle)
    step(1'b0, ENC_ACT, 3'h5, 16'h0000, 1'b1, CMD_ACT);
    ck(ENC_NOP, 1'b0, ST_APD);
    ck(ENC_NOP, 1'b1, ST_ACTIVE);
    step(1'b0, ENC_PRE, 3'h0, 16'h0400, 1'b1, CMD_PRE);
    ck(ENC_REF, 1'b0, ST_SREF);
    `CHK("refresh_allowed", 1'b1, refresh_allowed)
    ck(ENC_ACT, 1'b0, ST_SREF);
    `CHK("dec_valid", 1'b0, dec_valid)
    `CHK("sref_exit", 1'b0, sref_exit)
    fork
      ck(ENC_NOP, 1'b1, ST_IDLE);
      begin
        @(posedge ref_clk);
        #1;
        `CHK("sref_exit", 1'b1, sref_exit)
      end
    join
  endtask : t_power
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // watchdog at 5000 cycles, far beyond the 65 or so cycles the tests need
  initial begin
    #50000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("reset state", ST_IDLE, state)
    `CHK("reset dec_valid", 1'b0, dec_valid)
    `CHK("reset bank_open", 8'h00, bank_open)
    `CHK("settling is_idle", 1'b0, is_idle)
    t_decode();
    t_burst();
    t_power();
    tally_and_finish();
  end
endmodule : tb
